// [include/ipvb_pkg.sv]
package ipvb_pkg;

	// ----------------------------------------
	// bus and register indices
	// ----------------------------------------
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam int IDX_W = 6;
	localparam logic [IDX_W-1:0] IDX_PRIO_TIMERS = 6'h05;
	localparam logic [IDX_W-1:0] IDX_PRIO_PWM_ADC = 6'h06;
	localparam logic [IDX_W-1:0] IDX_VECTOR_BASE = 6'h07;
	localparam logic [IDX_W-1:0] IDX_FAST_IRQ0 = 6'h08;
	localparam logic [IDX_W-1:0] IDX_ARB_STATUS = 6'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// writable bit masks and reset values
	// ----------------------------------------
	localparam logic [REG_W-1:0] MASK_PRIO_TIMERS = 16'hFFFF;
	localparam logic [REG_W-1:0] MASK_PRIO_PWM_ADC = 16'h0FFF;
	localparam logic [REG_W-1:0] MASK_VECTOR_BASE = 16'h3FFF;
	localparam logic [REG_W-1:0] MASK_FAST_IRQ0 = 16'h003F;
	localparam logic [REG_W-1:0] PRIO_RESET = 16'h0000;
	localparam logic [REG_W-1:0] FAST_RESET = 16'h0000;
	localparam logic [REG_W-1:0] VBASE_RESET_LOW = 16'h0000;
	localparam logic [REG_W-1:0] VBASE_RESET_HIGH = 16'h0080;

	// ----------------------------------------
	// vector address composition
	// ----------------------------------------
	localparam int VBASE_W = 14;
	localparam int VLOW_W = 7;
	localparam int VADDR_W = VBASE_W + VLOW_W;
	localparam int VEC_W = 6;

	// ----------------------------------------
	// sources: register select, field lsb, vector number
	// ----------------------------------------
	localparam int NUM_SRC = 14;
	// 0 selects the timers register, 1 the pwm/adc register
	localparam bit SRC_REG [NUM_SRC] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1};
	// timer b ch0..3, comparator a, b, interval timer 0, 1, then
	// interval timer 2, adc a done, adc b done, adc zero cross, pwm reload, pwm fault
	localparam int SRC_LSB [NUM_SRC] = '{0, 2, 4, 6, 8, 10, 12, 14, 0, 2, 4, 6, 8, 10};
	// vector numbers, ascending with index
	localparam logic [VEC_W-1:0] SRC_VEC [NUM_SRC] = '{6'h28, 6'h29, 6'h2A, 6'h2B,
		6'h2C, 6'h2D, 6'h2E, 6'h2F, 6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35};

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		IPVB_WS_IDLE = 2'b00,
		IPVB_WS_ADDR = 2'b01,
		IPVB_WS_DATA = 2'b10,
		IPVB_WS_RESP = 2'b11
	} ipvb_wr_state_t;

	// field code 00 masks, 01..11 give levels 0..2
	localparam logic [1:0] FIELD_MASKED = 2'h0;

	// enable bit and level of one priority field
	function automatic logic [2:0] decode_field(input logic [1:0] field);
		logic [2:0] res;
		res = 3'h0;
		if (field != FIELD_MASKED)
			res = {1'b1, field - 2'h1};
		return res;
	endfunction : decode_field

endpackage : ipvb_pkg

// [include/ipvb_arb_if.sv]
`timescale 1ns/1ps
`default_nettype none

// carries priority state to the arbiter and the winner back
interface ipvb_arb_if;
	logic [ipvb_pkg::NUM_SRC-1:0][1:0] prio_field;
	logic [ipvb_pkg::NUM_SRC-1:0] src_req;
	logic [ipvb_pkg::VEC_W-1:0] fast0_vec;
	logic win_valid;
	logic [1:0] win_level;
	logic [ipvb_pkg::VEC_W-1:0] win_vec;
	logic win_fast;

	modport arb (input prio_field, input src_req, input fast0_vec,
		output win_valid, output win_level, output win_vec, output win_fast);
	modport ctl (output prio_field, output src_req, output fast0_vec,
		input win_valid, input win_level, input win_vec, input win_fast);
endinterface : ipvb_arb_if

`default_nettype wire

// [design/ipvb_arbiter.sv]
`timescale 1ns/1ps
`default_nettype none

module ipvb_arbiter
(
	ipvb_arb_if.arb bus
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	for (genvar g = 1; g < ipvb_pkg::NUM_SRC; g++)
	begin : g_chk
		if (ipvb_pkg::SRC_VEC[g] <= ipvb_pkg::SRC_VEC[g-1])
			$error("source vector numbers must ascend with index");
	end

	// ----------------------------------------
	// selection
	// ----------------------------------------
	logic [2:0] dec;
	logic hit_valid;
	logic [1:0] hit_level;
	logic [ipvb_pkg::VEC_W-1:0] hit_vec;
	logic fast_hit;

	// highest level wins, lowest vector within a level
	always_comb
	begin
		dec = 3'h0;
		hit_valid = 1'b0;
		hit_level = 2'h0;
		hit_vec = '0;
		fast_hit = 1'b0;
		// descending scan so the lowest index wins a tie
		for (int i = ipvb_pkg::NUM_SRC - 1; i >= 0; i--)
		begin
			dec = ipvb_pkg::decode_field(bus.prio_field[i]);
			if (bus.src_req[i] && dec[2] && (!hit_valid || dec[1:0] >= hit_level))
			begin
				hit_valid = 1'b1;
				hit_level = dec[1:0];
				hit_vec = ipvb_pkg::SRC_VEC[i];
			end
		end
		// fast source outranks every other level-2 request
		for (int i = 0; i < ipvb_pkg::NUM_SRC; i++)
		begin
			dec = ipvb_pkg::decode_field(bus.prio_field[i]);
			if (bus.src_req[i] && dec[2] && dec[1:0] == 2'h2
				&& ipvb_pkg::SRC_VEC[i] == bus.fast0_vec)
			begin
				fast_hit = 1'b1;
				hit_vec = ipvb_pkg::SRC_VEC[i];
				hit_level = dec[1:0];
				hit_valid = 1'b1;
			end
		end
	end

	assign bus.win_valid = hit_valid;
	assign bus.win_level = hit_level;
	assign bus.win_vec = hit_vec;
	assign bus.win_fast = fast_hit;

endmodule : ipvb_arbiter

`default_nettype wire

// [design/ipvb_top.sv]
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - field 00 masks the source; 01, 10, 11 give levels 0, 1, 2.
// - all priority fields reset to zero, so every source starts masked.
// - timers register: pit1, pit0, comparator b, a, timer b ch3..ch0 from top.
// - pwm/adc register: pwm fault, reload, adc zero cross, adc b, adc a, pit2.
// - reserved bits of pwm/adc and vector base registers read zero.
// - vector base field supplies the upper 14 bits of the vector address.
// - low 7 address bits come from the winning source, placed beneath the base.
// - vector base reset value is a build parameter, 0x0000 or 0x0080.
// - fast irq0 match holds a vector number in bits 5-0; upper bits read zero.
// - a matched level-2 source is the top level-2 interrupt.
module ipvb_top
#(
	parameter int ADDR_W = 8,
	parameter logic [15:0] VBASE_RESET = ipvb_pkg::VBASE_RESET_LOW
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [ipvb_pkg::NUM_SRC-1:0] irq_src_req,
	output logic [ipvb_pkg::VADDR_W-1:0] vector_address_out,
	output logic irq_request_out,
	output logic [1:0] irq_level_out,
	output logic fast_irq0_active_out
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (ADDR_W < ipvb_pkg::IDX_W + 2 || ADDR_W > 32)
		$error("address width must hold every register index");
	if ((VBASE_RESET != ipvb_pkg::VBASE_RESET_LOW) && (VBASE_RESET != ipvb_pkg::VBASE_RESET_HIGH))
		$error("vector base reset must be one of the two build variants");

	// ----------------------------------------
	// local functions
	// ----------------------------------------

	// merge a bus write into a 16-bit register under strobes and mask
	function automatic logic [15:0] merge_write(
		input logic [15:0] old_val,
		input logic [31:0] data,
		input logic [3:0] strb,
		input logic [15:0] mask
	);
		logic [15:0] res;
		res = old_val;
		if (strb[0])
			res[7:0] = data[7:0];
		if (strb[1])
			res[15:8] = data[15:8];
		return res & mask;
	endfunction : merge_write

	// register index of a byte address
	function automatic logic [ipvb_pkg::IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
		return addr[ipvb_pkg::IDX_W+1:2];
	endfunction : reg_index

	// true when upper address bits are clear
	function automatic logic upper_clear(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] hi;
		hi = addr >> (ipvb_pkg::IDX_W + 2);
		return hi == '0;
	endfunction : upper_clear

	// true for an index that a write may target
	function automatic logic is_writable(input logic [ipvb_pkg::IDX_W-1:0] idx);
		return (idx == ipvb_pkg::IDX_PRIO_TIMERS) || (idx == ipvb_pkg::IDX_PRIO_PWM_ADC)
			|| (idx == ipvb_pkg::IDX_VECTOR_BASE) || (idx == ipvb_pkg::IDX_FAST_IRQ0);
	endfunction : is_writable

	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	logic [15:0] priority_reg_timers_comparators_reg;
	logic [15:0] priority_reg_pwm_adc_reg;
	logic [15:0] vector_base_reg;
	logic [15:0] fast_irq0_match_reg;
	ipvb_pkg::ipvb_wr_state_t wr_state_reg;
	ipvb_pkg::ipvb_wr_state_t wr_state_next;
	logic [ADDR_W-1:0] waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic [ipvb_pkg::VADDR_W-1:0] vaddr_reg;
	logic irq_req_reg;
	logic [1:0] irq_level_reg;
	logic fast_reg;

	logic aw_fire;
	logic w_fire;
	logic ar_fire;
	logic commit;
	logic [ADDR_W-1:0] eff_addr;
	logic [31:0] eff_data;
	logic [3:0] eff_strb;
	logic [ipvb_pkg::IDX_W-1:0] eff_idx;
	logic eff_ok;
	logic [ipvb_pkg::IDX_W-1:0] rd_idx;
	logic [31:0] rd_val;
	logic rd_ok;

	ipvb_arb_if arb_bus ();

	// ----------------------------------------
	// write channel handshakes
	// ----------------------------------------

	// address and data taken in either order, then one response
	assign s_axi_awready = (wr_state_reg == ipvb_pkg::IPVB_WS_IDLE)
		|| (wr_state_reg == ipvb_pkg::IPVB_WS_DATA);
	assign s_axi_wready = (wr_state_reg == ipvb_pkg::IPVB_WS_IDLE)
		|| (wr_state_reg == ipvb_pkg::IPVB_WS_ADDR);
	assign s_axi_bvalid = (wr_state_reg == ipvb_pkg::IPVB_WS_RESP);
	assign s_axi_bresp = bresp_reg;
	assign aw_fire = s_axi_awvalid && s_axi_awready;
	assign w_fire = s_axi_wvalid && s_axi_wready;

	// write happens in the cycle the second half arrives
	assign commit = (wr_state_reg == ipvb_pkg::IPVB_WS_IDLE && aw_fire && w_fire)
		|| (wr_state_reg == ipvb_pkg::IPVB_WS_ADDR && w_fire)
		|| (wr_state_reg == ipvb_pkg::IPVB_WS_DATA && aw_fire);
	assign eff_addr = aw_fire ? s_axi_awaddr : waddr_reg;
	assign eff_data = w_fire ? s_axi_wdata : wdata_reg;
	assign eff_strb = w_fire ? s_axi_wstrb : wstrb_reg;
	assign eff_idx = reg_index(eff_addr);
	assign eff_ok = upper_clear(eff_addr) && is_writable(eff_idx);

	// next write state
	always_comb
	begin
		wr_state_next = wr_state_reg;
		unique case (wr_state_reg)
			ipvb_pkg::IPVB_WS_IDLE:
			begin
				if (commit)
					wr_state_next = ipvb_pkg::IPVB_WS_RESP;
				else if (aw_fire)
					wr_state_next = ipvb_pkg::IPVB_WS_ADDR;
				else if (w_fire)
					wr_state_next = ipvb_pkg::IPVB_WS_DATA;
			end
			ipvb_pkg::IPVB_WS_ADDR, ipvb_pkg::IPVB_WS_DATA:
			begin
				if (commit)
					wr_state_next = ipvb_pkg::IPVB_WS_RESP;
			end
			ipvb_pkg::IPVB_WS_RESP:
			begin
				if (s_axi_bready)
					wr_state_next = ipvb_pkg::IPVB_WS_IDLE;
			end
		endcase
	end

	// write state register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wr_state_reg <= ipvb_pkg::IPVB_WS_IDLE;
		else
			wr_state_reg <= wr_state_next;
	end

	// hold whichever half came first
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			waddr_reg <= '0;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end
		else
		begin
			if (aw_fire)
				waddr_reg <= s_axi_awaddr;
			if (w_fire)
			begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
		end
	end

	// write response code
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bresp_reg <= ipvb_pkg::RESP_OKAY;
		else if (commit)
			bresp_reg <= eff_ok ? ipvb_pkg::RESP_OKAY : ipvb_pkg::RESP_SLVERR;
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------

	// priority fields, all masked after reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			priority_reg_timers_comparators_reg <= ipvb_pkg::PRIO_RESET;
			priority_reg_pwm_adc_reg <= ipvb_pkg::PRIO_RESET;
		end
		else if (commit && eff_ok)
		begin
			if (eff_idx == ipvb_pkg::IDX_PRIO_TIMERS)
				priority_reg_timers_comparators_reg <= merge_write(
					priority_reg_timers_comparators_reg, eff_data, eff_strb,
					ipvb_pkg::MASK_PRIO_TIMERS);
			if (eff_idx == ipvb_pkg::IDX_PRIO_PWM_ADC)
				priority_reg_pwm_adc_reg <= merge_write(priority_reg_pwm_adc_reg,
					eff_data, eff_strb, ipvb_pkg::MASK_PRIO_PWM_ADC);
		end
	end

	// vector base, reset value chosen per build
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			vector_base_reg <= VBASE_RESET & ipvb_pkg::MASK_VECTOR_BASE;
		else if (commit && eff_ok && eff_idx == ipvb_pkg::IDX_VECTOR_BASE)
			vector_base_reg <= merge_write(vector_base_reg, eff_data, eff_strb,
				ipvb_pkg::MASK_VECTOR_BASE);
	end

	// fast irq0 source match
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			fast_irq0_match_reg <= ipvb_pkg::FAST_RESET;
		else if (commit && eff_ok && eff_idx == ipvb_pkg::IDX_FAST_IRQ0)
			fast_irq0_match_reg <= merge_write(fast_irq0_match_reg, eff_data, eff_strb,
				ipvb_pkg::MASK_FAST_IRQ0);
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	assign s_axi_arready = !rvalid_reg;
	assign ar_fire = s_axi_arvalid && s_axi_arready;
	assign rd_idx = reg_index(s_axi_araddr);

	// read mux, reserved bits zero
	always_comb
	begin
		rd_val = 32'h00000000;
		rd_ok = upper_clear(s_axi_araddr);
		unique case (rd_idx)
			ipvb_pkg::IDX_PRIO_TIMERS:
				rd_val[15:0] = priority_reg_timers_comparators_reg;
			ipvb_pkg::IDX_PRIO_PWM_ADC:
				rd_val[15:0] = priority_reg_pwm_adc_reg & ipvb_pkg::MASK_PRIO_PWM_ADC;
			ipvb_pkg::IDX_VECTOR_BASE:
				rd_val[15:0] = vector_base_reg & ipvb_pkg::MASK_VECTOR_BASE;
			ipvb_pkg::IDX_FAST_IRQ0:
				rd_val[15:0] = fast_irq0_match_reg & ipvb_pkg::MASK_FAST_IRQ0;
			ipvb_pkg::IDX_ARB_STATUS:
				rd_val[15:0] = {6'h00, fast_reg, irq_req_reg, irq_level_reg,
					vaddr_reg[ipvb_pkg::VLOW_W-1:1]};
			default:
				rd_ok = 1'b0;
		endcase
	end

	// read data holds until taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= ipvb_pkg::RESP_OKAY;
		end
		else if (ar_fire)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_ok ? rd_val : 32'h00000000;
			rresp_reg <= rd_ok ? ipvb_pkg::RESP_OKAY : ipvb_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// ----------------------------------------
	// arbitration
	// ----------------------------------------

	// route each source's field out of its register
	for (genvar s = 0; s < ipvb_pkg::NUM_SRC; s++)
	begin : g_field
		if (ipvb_pkg::SRC_REG[s])
		begin : g_pwm
			assign arb_bus.prio_field[s] =
				priority_reg_pwm_adc_reg[ipvb_pkg::SRC_LSB[s] +: 2];
		end
		else
		begin : g_tmr
			assign arb_bus.prio_field[s] =
				priority_reg_timers_comparators_reg[ipvb_pkg::SRC_LSB[s] +: 2];
		end
	end

	assign arb_bus.src_req = irq_src_req;
	assign arb_bus.fast0_vec = fast_irq0_match_reg[ipvb_pkg::VEC_W-1:0];

	ipvb_arbiter u_arbiter
	(
		.bus(arb_bus.arb)
	);

	// ----------------------------------------
	// vector address to the core
	// ----------------------------------------

	// base on top, winner's table slot beneath
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			vaddr_reg <= '0;
			irq_req_reg <= 1'b0;
			irq_level_reg <= 2'h0;
			fast_reg <= 1'b0;
		end
		else
		begin
			vaddr_reg <= {vector_base_reg[ipvb_pkg::VBASE_W-1:0],
				arb_bus.win_vec, 1'b0};
			irq_req_reg <= arb_bus.win_valid;
			irq_level_reg <= arb_bus.win_level;
			fast_reg <= arb_bus.win_fast;
		end
	end

	assign vector_address_out = vaddr_reg;
	assign irq_request_out = irq_req_reg;
	assign irq_level_out = irq_level_reg;
	assign fast_irq0_active_out = fast_reg;

endmodule : ipvb_top

`default_nettype wire

// [sim/ipvb_core_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// core taking interrupt vectors
// ----------------------------------------
module ipvb_core_model
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic irq_request_out,
	input wire logic [20:0] vector_address_out,
	input wire logic [1:0] irq_level_out,
	input wire logic fast_irq0_active_out,
	input wire logic [3:0] ack_delay,
	output logic took,
	output logic [23:0] took_info
);
	logic [3:0] wait_reg;
	logic done_reg;

	// one take per request, after a chosen delay
	always_ff @(posedge aclk)
	begin
		took <= 1'h0;
		if (!aresetn || !irq_request_out)
		begin
			wait_reg <= 4'h0;
			done_reg <= 1'h0;
		end
		else if (!done_reg && wait_reg == ack_delay)
		begin
			took <= 1'h1;
			took_info <= {fast_irq0_active_out, irq_level_out, vector_address_out};
			done_reg <= 1'h1;
		end
		else if (!done_reg)
			wait_reg <= wait_reg + 4'h1;
	end
endmodule : ipvb_core_model

`default_nettype wire

// [sim/ipvb_top_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// port checker
// ----------------------------------------
module ipvb_checker
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [ipvb_pkg::NUM_SRC-1:0] irq_src_req,
	input wire logic [ipvb_pkg::VADDR_W-1:0] vector_address_out,
	input wire logic irq_request_out,
	input wire logic [1:0] irq_level_out,
	input wire logic fast_irq0_active_out
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// bus answers and refusals
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
	wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during answer");
	wr_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
		&& s_axi_awready) else $error("write answer not released");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
		&& !s_axi_arready) else $error("read answer late");
	rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("read upper half not zero");

	// interrupt outputs against their causes
	level_range_a: assert property (irq_request_out |-> irq_level_out != 2'h3)
		else $error("level above two");
	rise_cause_a: assert property ($rose(irq_request_out) |-> $past(irq_src_req) != 14'h0)
		else $error("request without source");
	idle_out_a: assert property (irq_src_req == 14'h0 |=> !irq_request_out
		&& irq_level_out == 2'h0) else $error("request while idle");
	fast_level_a: assert property (fast_irq0_active_out |-> irq_request_out
		&& irq_level_out == 2'h2) else $error("fast winner not level two");
	base_hold_a: assert property ($changed(vector_address_out[20:7]) |->
		$past(s_axi_bvalid) || !$past(aresetn, 2)) else $error("base moved without write");

	write_seen_c: cover property (s_axi_bvalid && s_axi_bready);
	read_seen_c: cover property (s_axi_rvalid && s_axi_rready);
	fast_seen_c: cover property (fast_irq0_active_out);
endmodule : ipvb_checker

bind ipvb_top ipvb_checker u_checker
(
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata),
	.irq_src_req(irq_src_req),
	.vector_address_out(vector_address_out),
	.irq_request_out(irq_request_out),
	.irq_level_out(irq_level_out),
	.fast_irq0_active_out(fast_irq0_active_out)
);

`default_nettype wire

// [sim/test_irq_priority_vector_base.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// self-checking bench
// ----------------------------------------
module test_irq_priority_vector_base;
	localparam logic [15:0] VB_RST = ipvb_pkg::VBASE_RESET_HIGH;
	localparam logic [33:0] OK_W = {ipvb_pkg::RESP_OKAY, 32'h00000000};
	localparam logic [33:0] ERR_W = {ipvb_pkg::RESP_SLVERR, 32'h00000000};
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, ack_delay, s;
	logic [1:0] s_axi_bresp, s_axi_rresp, irq_level_out;
	logic [13:0] irq_src_req, rq;
	logic [20:0] vector_address_out;
	logic irq_request_out, fast_irq0_active_out, took;
	logic [23:0] took_info;
	logic [33:0] exp_q [$];
	logic [33:0] nxt;
	logic [15:0] cur, vb, t, p;
	int fail_count = 0;
	int check_count = 0;
	int seed, k;

	ipvb_top #(.VBASE_RESET(VB_RST)) DUT (.*);
	ipvb_core_model u_core (.*);

	// 20 MHz clock
	initial
	begin
		aclk = 1'h0;
		forever #25 aclk = ~aclk;
	end

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// compare each appearing result with the oldest note
	always @(posedge aclk)
	begin
		if (took || (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
		begin
			nxt = (exp_q.size() > 0) ? exp_q.pop_front() : 34'hX;
			if (took)
				check("vector", {10'h000, took_info}, nxt);
			else if (s_axi_bvalid)
				check("write", {s_axi_bresp, 32'h00000000}, nxt);
			else
				check("read", {s_axi_rresp, s_axi_rdata}, nxt);
		end
	end

	// one bus transfer, expectation noted first
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] st, input logic [33:0] e);
		int n;
		@(posedge aclk);
		exp_q.push_back(e);
		if (wr)
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_wstrb <= st;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
		end
		else
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
		end
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_bvalid || s_axi_rvalid)
				break;
		end
		s_axi_bready <= 1'h0;
		s_axi_rready <= 1'h0;
		if (n == 40)
		begin
			fail_count++;
			summarize();
		end
	endtask : bus

	// expected winner: top level, lowest index, fast match first
	function automatic logic [33:0] winner(input logic [15:0] tv, input logic [15:0] pv,
		input logic [13:0] rv, input logic [5:0] f);
		logic [1:0] c, bl;
		int w;
		logic fs;
		w = -1;
		bl = 2'h0;
		fs = 1'h0;
		for (int i = 0; i < 14; i++)
		begin
			c = ipvb_pkg::SRC_REG[i] ? pv[ipvb_pkg::SRC_LSB[i]+:2] : tv[ipvb_pkg::SRC_LSB[i]+:2];
			if (rv[i] && c != 2'h0 && (w < 0 || c > bl || (c == 2'h3 && ipvb_pkg::SRC_VEC[i] == f)))
			begin
				w = i;
				bl = c;
				fs = (c == 2'h3 && ipvb_pkg::SRC_VEC[i] == f);
			end
		end
		if (w < 0)
			return 34'h0;
		return {10'h000, fs, bl - 2'h1, vb[13:0], ipvb_pkg::SRC_VEC[w], 1'h0};
	endfunction : winner

	// program fields, raise sources, await the core
	task automatic irq_round(input logic [15:0] tv, input logic [15:0] pv,
		input logic [13:0] rv, input logic [5:0] f);
		logic [33:0] e;
		int n;
		e = winner(tv, pv, rv, f);
		bus(1'h1, 8'h14, {16'h0000, tv}, 4'hF, OK_W);
		bus(1'h1, 8'h18, {16'h0000, pv}, 4'hF, OK_W);
		bus(1'h1, 8'h20, {26'h0, f}, 4'hF, OK_W);
		if (e != 34'h0)
			exp_q.push_back(e);
		@(posedge aclk);
		irq_src_req <= rv;
		repeat (3) @(posedge aclk);
		if (e == 34'h0)
			check("idle", {33'h0, irq_request_out}, 34'h0);
		for (n = 0; n < 60 && exp_q.size() > 0; n++)
			@(posedge aclk);
		irq_src_req <= 14'h0000;
		repeat (2) @(posedge aclk);
		if (n == 60)
		begin
			fail_count++;
			summarize();
		end
	endtask : irq_round

	initial
	begin
		seed = 82;
		{s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid} = '0;
		{s_axi_rready, irq_src_req, ack_delay, aresetn} = '0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		check("reset vector", {13'h0, vector_address_out}, {13'h0, VB_RST[13:0], 7'h00});
		for (int i = 0; i < 4; i++)
			bus(1'h0, 8'h14 + 8'(4 * i), 32'h0, 4'h0, {ipvb_pkg::RESP_OKAY, 16'h0000,
				(i == 2) ? VB_RST : 16'h0000});
		bus(1'h0, 8'h3C, 32'h0, 4'h0, ERR_W);
		// all ones written on purpose: reserved bits must come back zero
		for (int i = 0; i < 4; i++)
		begin
			bus(1'h1, 8'h14 + 8'(4 * i), 32'hFFFFFFFF, 4'hF, OK_W);
			cur = (i == 0) ? ipvb_pkg::MASK_PRIO_TIMERS : (i == 1) ? ipvb_pkg::MASK_PRIO_PWM_ADC
				: (i == 2) ? ipvb_pkg::MASK_VECTOR_BASE : ipvb_pkg::MASK_FAST_IRQ0;
			bus(1'h0, 8'h14 + 8'(4 * i), 32'h0, 4'h0, {ipvb_pkg::RESP_OKAY, 16'h0000, cur});
		end
		bus(1'h1, 8'h40, 32'hFFFFFFFF, 4'hF, ERR_W);
		bus(1'h1, 8'h3C, 32'hFFFFFFFF, 4'hF, ERR_W);
		// random byte strobes on the timers register
		cur = 16'hFFFF;
		for (int i = 0; i < 4; i++)
		begin
			t = 16'($random(seed));
			s = 4'($random(seed));
			bus(1'h1, 8'h14, {16'h0000, t}, s, OK_W);
			cur = {s[1] ? t[15:8] : cur[15:8], s[0] ? t[7:0] : cur[7:0]};
			bus(1'h0, 8'h14, 32'h0, 4'h0, {ipvb_pkg::RESP_OKAY, 16'h0000, cur});
		end
		vb = {2'h0, 14'($random(seed))};
		bus(1'h1, 8'h1C, {16'h0000, vb}, 4'hF, OK_W);
		// every code of every field, one source at a time
		for (int i = 0; i < 14; i++)
			for (int c = 0; c < 4; c++)
			begin
				t = ipvb_pkg::SRC_REG[i] ? 16'h0000 : 16'(c << ipvb_pkg::SRC_LSB[i]);
				p = ipvb_pkg::SRC_REG[i] ? 16'(c << ipvb_pkg::SRC_LSB[i]) : 16'h0000;
				ack_delay <= 4'(c * 3);
				irq_round(t, p, 14'h0001 << i, 6'h00);
			end
		// random contention with a fast source at level two
		for (int r = 0; r < 8; r++)
		begin
			k = {$random(seed)} % 14;
			t = 16'($random(seed));
			p = 16'($random(seed)) & ipvb_pkg::MASK_PRIO_PWM_ADC;
			if (ipvb_pkg::SRC_REG[k])
				p[ipvb_pkg::SRC_LSB[k]+:2] = 2'h3;
			else
				t[ipvb_pkg::SRC_LSB[k]+:2] = 2'h3;
			rq = 14'($random(seed));
			rq[k] = r[0];
			ack_delay <= 4'($random(seed));
			irq_round(t, p, rq, ipvb_pkg::SRC_VEC[k]);
		end
		// status reads all clear once every source is quiet
		bus(1'h0, 8'h40, 32'h0, 4'h0, OK_W);
		summarize();
	end
endmodule : test_irq_priority_vector_base

`default_nettype wire
